// ### sxc_pkg.sv
// Purpose: shared constants for the six-channel converter readout block
// Assumes: 125 MHz system clock
// Notes:   timing counts derive from times in their own units
package sxc_pkg;
	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int CLK_MHZ            = 125;          // system clock rate
	localparam int CONVERSION_TIME_NS = 3000;         // conversion time 3 us
	localparam int CONV_CYCLES        = (CONVERSION_TIME_NS * CLK_MHZ) / 1000;
	// ------------------------------------------------------------
	// geometry and modes
	// ------------------------------------------------------------
	localparam int NUM_CH             = 6;            // channels
	localparam int NUM_PAIRS          = 3;            // start pairs
	localparam int DATA_W             = 16;           // data lines
	localparam logic MODE_WORD        = 1'b0;         // word/byte select low
	localparam logic MODE_BYTE        = 1'b1;         // word/byte select high
	localparam logic ORDER_LOW_FIRST  = 1'b0;         // byte order select low
	localparam logic SEL_PARALLEL     = 1'b0;         // serial/parallel select low
	localparam logic [2:0] IDX_RST    = 3'h0;         // sequencer reset index
endpackage

// ### sxc_sync.sv
// Purpose: three-stage synchroniser with agreement filter for pin inputs
// Assumes: input is asynchronous to clk
// Notes:   output changes once stages two and three agree
module sxc_sync
	import sxc_pkg::*;
#(
	parameter int W = 1
) (
	input  wire logic         clk,
	input  wire logic         sys_rst,
	input  wire logic [W-1:0] pin_in,
	input  wire logic [W-1:0] rst_val,
	output logic      [W-1:0] pin_out
);
	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	typedef struct packed {
		logic [W-1:0] s1;   // first stage, read only by s2
		logic [W-1:0] s2;   // second stage
		logic [W-1:0] s3;   // third stage
		logic [W-1:0] q;    // filtered level
	} sxc_sync_type;
	sxc_sync_type st_r;
	sxc_sync_type st_nxt;

	// next state: shift, update filtered level where stages agree
	always_comb begin
		st_nxt    = st_r;
		st_nxt.s1 = pin_in;
		st_nxt.s2 = st_r.s1;
		st_nxt.s3 = st_r.s2;
		for (int i = 0; i < W; i++) begin
			if (st_r.s2[i] == st_r.s3[i]) begin
				st_nxt.q[i] = st_r.s3[i];
			end
		end
	end

	// synchronous reset loads the idle level so no false edge appears
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			st_r <= '{s1: rst_val, s2: rst_val, s3: rst_val, q: rst_val};
		end else begin
			st_r <= st_nxt;
		end
	end

	assign pin_out = st_r.q;
endmodule

// ### sxc_conv_timer.sv
// Purpose: conversion timer standing in for the on-chip oscillator
// Assumes: start is a one-cycle pulse on clk
// Notes:   a start while running is ignored
module sxc_conv_timer
	import sxc_pkg::*;
#(
	parameter int CYCLES = CONV_CYCLES
) (
	input  wire logic clk,
	input  wire logic sys_rst,
	input  wire logic start,
	output logic      running,
	output logic      done
);
	localparam int CW = $clog2(CYCLES + 1);
	// refuse spans too short for the run and end handshake
	if (CYCLES < 2) begin : g_bad_cycles
		$error("conversion cycles too small");
	end

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	typedef struct packed {
		logic          run;   // conversion in progress
		logic [CW-1:0] cnt;   // cycles left
		logic          fin;   // end pulse
	} sxc_tmr_type;
	sxc_tmr_type st_r;
	sxc_tmr_type st_nxt;

	// count down the conversion span
	always_comb begin
		st_nxt     = st_r;
		st_nxt.fin = 1'b0;
		if (!st_r.run && start) begin
			st_nxt.run = 1'b1;
			st_nxt.cnt = CW'(CYCLES - 1);
		end else if (st_r.run) begin
			if (st_r.cnt == '0) begin
				st_nxt.run = 1'b0;
				st_nxt.fin = 1'b1;
			end else begin
				st_nxt.cnt = st_r.cnt - 1'b1;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign running = st_r.run;
	assign done    = st_r.fin;
endmodule

// ### sxc_readout.sv
// Purpose: conversion start and parallel readout of a six-channel converter
// Assumes: pins asynchronous to clk; sample codes come from the analog cores
// Notes:   data pins are split into in, out and output enable
//
// What this block does
// - word/byte select low word, high byte
// - start rising edge launches selected pair conversions
// - own timer times conversion of 3 us
// - busy falls at end, tracking resumes
// - start inputs map to pairs one, two, three
// - results held in output data registers
// - data lines driven only when select and read low
// - word mode one channel per read
// - results presented in ascending channel order
// - 14-bit variant zeros top two bits
// - 12-bit variant zeros top four bits
// - byte mode data7 pin selects order, upper lines
// - order low gives low byte first
// - byte mode six channels take twelve reads
// - busy high for whole conversion
// - results are two's complement
module sxc_readout
	import sxc_pkg::*;
#(
	parameter int RES_W       = 16,            // converter resolution: 16, 14 or 12
	parameter int CONV_CYC    = CONV_CYCLES    // conversion span in clk cycles
) (
	input  wire logic                clk,
	input  wire logic                sys_rst,
	input  wire logic                start_pair_one_n,
	input  wire logic                start_pair_two_n,
	input  wire logic                start_pair_three_n,
	input  wire logic                serial_parallel_select,
	input  wire logic                word_byte_select,
	input  wire logic                chip_select_n,
	input  wire logic                read_n,
	input  wire logic [DATA_W-1:0]   data_in,
	output logic      [DATA_W-1:0]   data_out,
	output logic      [DATA_W-1:0]   data_oe,
	output logic                     busy,
	output logic                     track,
	input  wire logic [NUM_CH*RES_W-1:0] sample_code
);
	// refuse resolutions the alignment cannot serve, and spans shorter than
	// the busy-span check expects; both are caught before any clock runs
	if (RES_W != 16 && RES_W != 14 && RES_W != 12) begin : g_bad_res
		$error("resolution must be 16, 14 or 12");
	end
	if (CONV_CYC < 8) begin : g_bad_span
		$error("conversion span below 8 cycles");
	end

	// ------------------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------------------
	logic [7:0] pins_raw;   // async pins gathered
	logic [7:0] pins_s;     // filtered levels
	// the interface select is a pin as well, so it is filtered like the rest
	assign pins_raw = {serial_parallel_select, data_in[7], read_n, chip_select_n,
	                   word_byte_select, start_pair_three_n, start_pair_two_n,
	                   start_pair_one_n};

	// idle levels: starts and strobes high, parallel, low byte first
	sxc_sync #(.W(8)) u_sync (
		.clk     (clk),
		.sys_rst (sys_rst),
		.pin_in  (pins_raw),
		.rst_val (8'h3f),
		.pin_out (pins_s)
	);

	logic [2:0] start_s;    // filtered start levels, pairs one..three
	logic       wb_s;       // word/byte mode
	logic       cs_n_s;     // chip select
	logic       rd_n_s;     // read strobe
	logic       order_s;    // byte order select on shared data7 pin
	assign start_s = pins_s[2:0];
	assign wb_s    = pins_s[3];
	assign cs_n_s  = pins_s[4];
	assign rd_n_s  = pins_s[5];
	assign order_s = pins_s[6];

	// ------------------------------------------------------------
	// helper functions
	// ------------------------------------------------------------
	// zero-extending right alignment: code already two's complement, top bits zero
	function automatic logic [DATA_W-1:0] align_code(input logic [RES_W-1:0] c);
		align_code = DATA_W'(c);
	endfunction

	// lowest set channel at or above a given index, NUM_CH if none
	function automatic logic [2:0] next_ch(input logic [NUM_CH-1:0] m, input logic [2:0] from);
		next_ch = 3'(NUM_CH);
		for (int i = NUM_CH - 1; i >= 0; i--) begin
			if (m[i] && 3'(i) >= from) begin
				next_ch = 3'(i);
			end
		end
	endfunction

	// ------------------------------------------------------------
	// conversion timer
	// ------------------------------------------------------------
	logic tmr_start;   // one-cycle launch
	logic tmr_run;     // conversion in progress
	logic tmr_done;    // conversion end pulse

	sxc_conv_timer #(.CYCLES(CONV_CYC)) u_tmr (
		.clk     (clk),
		.sys_rst (sys_rst),
		.start   (tmr_start),
		.running (tmr_run),
		.done    (tmr_done)
	);

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	// span counter wide enough for the whole busy time plus one
	localparam int SW = $clog2(CONV_CYC + 2);
	typedef struct packed {
		logic [2:0]                start_d;  // previous start levels
		logic [2:0]                pend;     // pairs being converted
		logic [NUM_CH-1:0]         valid;    // channels with stored results
		logic [NUM_CH*RES_W-1:0]   res;      // output data registers
		logic [2:0]                idx;      // read sequencer channel
		logic                      second;   // second byte of channel due
		logic                      rd_d;     // previous read strobe
		logic [DATA_W-1:0]         dout;     // registered data lines
		logic                      oe;       // data lines enabled
		logic                      trk;      // sampling stages tracking
		logic [SW-1:0]             span;     // busy cycles since launch
	} sxc_rd_type;
	sxc_rd_type st_r;
	sxc_rd_type st_nxt;

	logic [2:0] rise;   // start rising edges this cycle
	logic       rd_rise; // read strobe rising edge
	logic       par_ok;  // parallel interface selected
	assign par_ok  = (pins_s[7] == SEL_PARALLEL);
	assign rise    = start_s & ~st_r.start_d;
	assign rd_rise = rd_n_s & ~st_r.rd_d;
	// starts while busy are ignored; the host must not issue them
	assign tmr_start = (|rise) && !tmr_run;

	// next state: launch, capture, read sequencing, data drive
	always_comb begin
		logic [15:0]  word;
		logic [2:0]   ch;
		logic [RES_W-1:0] code;
		word   = '0;
		ch     = '0;
		code   = '0;
		st_nxt = st_r;
		st_nxt.start_d = start_s;
		st_nxt.rd_d    = rd_n_s;
		// busy span counter, read only by the conversion-time check;
		// kept apart from the timer so the check does not trust the timer
		if (tmr_start) begin
			st_nxt.span = '0;
		end else if (tmr_run) begin
			st_nxt.span = st_r.span + 1'b1;
		end
		// launch on start rising edge; each input selects its own pair
		if (tmr_start) begin
			st_nxt.pend   = rise;
			st_nxt.trk    = 1'b0;     // hold
			st_nxt.valid  = '0;
			st_nxt.idx    = IDX_RST;
			st_nxt.second = 1'b0;
		end
		// conversion end: store results of the converted pairs
		if (tmr_done) begin
			st_nxt.trk = 1'b1;
			for (int p = 0; p < NUM_PAIRS; p++) begin
				if (st_r.pend[p]) begin
					st_nxt.res[2*p*RES_W +: 2*RES_W] = sample_code[2*p*RES_W +: 2*RES_W];
					st_nxt.valid[2*p +: 2] = 2'b11;
				end
			end
			st_nxt.idx = next_ch(st_nxt.valid, IDX_RST);
		end
		// sequencer advances on read rising edge
		if (rd_rise && !tmr_done && st_r.idx < 3'(NUM_CH)) begin
			if (wb_s == MODE_BYTE && !st_r.second) begin
				st_nxt.second = 1'b1;
			end else begin
				st_nxt.second = 1'b0;
				st_nxt.idx = next_ch(st_r.valid, st_r.idx + 3'h1);
			end
		end
		// present the current channel
		ch = st_r.idx;
		if (ch < 3'(NUM_CH)) begin
			code = st_r.res[ch*RES_W +: RES_W];
			word = align_code(code);
		end
		if (wb_s == MODE_WORD) begin
			st_nxt.dout = word;
		end else begin
			// byte mode: one byte on the upper lines, lower lines idle
			st_nxt.dout = '0;
			if ((order_s == ORDER_LOW_FIRST) ^ st_r.second) begin
				st_nxt.dout[15:8] = word[7:0];
			end else begin
				st_nxt.dout[15:8] = word[15:8];
			end
		end
		st_nxt.oe = par_ok && !cs_n_s && !rd_n_s;
	end

	// register the state copy
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			st_r         <= '0;
			st_r.start_d <= 3'h7;
			st_r.rd_d    <= 1'b1;
			st_r.idx     <= 3'(NUM_CH);
			st_r.trk     <= 1'b1;
		end else begin
			st_r <= st_nxt;
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign busy     = tmr_run;
	assign track    = st_r.trk;
	assign data_out = st_r.dout;
	// byte mode keeps the shared data7 pin and lines below it as inputs
	assign data_oe  = !st_r.oe ? '0 :
	                  (wb_s == MODE_WORD) ? '1 : 16'hff00;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	// these watch what this block drives; the strobe-side duties of the
	// host are kept by the host model, not asserted here
	// track is registered, so it rises one cycle after busy falls
	chk_busy_span: assert property (@(posedge clk) disable iff (sys_rst)
		$rose(busy) |-> busy [*8]) else $error("busy span too short");
	chk_start_busy: assert property (@(posedge clk) disable iff (sys_rst)
		(tmr_start) |=> busy) else $error("busy not raised after start");
	chk_busy_end: assert property (@(posedge clk) disable iff (sys_rst)
		$fell(busy) |=> track) else $error("not tracking after busy");
	chk_oe_gate: assert property (@(posedge clk) disable iff (sys_rst)
		(|data_oe) |-> $past(!cs_n_s && !rd_n_s)) else $error("bus driven without strobes");
	chk_top_zero: assert property (@(posedge clk) disable iff (sys_rst)
		(RES_W == 14 && wb_s == MODE_WORD && st_r.oe) |-> data_out[15:14] == 2'b00)
		else $error("top bits not zero");
	chk_top_four: assert property (@(posedge clk) disable iff (sys_rst)
		(RES_W == 12 && wb_s == MODE_WORD && st_r.oe) |-> data_out[15:12] == 4'h0)
		else $error("top four bits not zero");
	chk_seq_reset: assert property (@(posedge clk) disable iff (sys_rst)
		tmr_start |=> (st_r.idx == IDX_RST && !st_r.second)) else $error("sequencer not reset");
	chk_byte_hold: assert property (@(posedge clk) disable iff (sys_rst)
		(rd_rise && !tmr_done && wb_s == MODE_BYTE && !st_r.second && st_r.idx < 3'(NUM_CH))
		|=> $stable(st_r.idx)) else $error("advanced after one byte");
	chk_ascending: assert property (@(posedge clk) disable iff (sys_rst)
		(rd_rise && !tmr_done && !tmr_start && st_r.idx < 3'(NUM_CH) && wb_s == MODE_WORD)
		|=> st_r.idx > $past(st_r.idx)) else $error("order not ascending");
	// the span counter must read the full conversion length as busy drops;
	// a counter instead of a delay keeps long spans cheap for the tools
	chk_conv_len: assert property (@(posedge clk) disable iff (sys_rst)
		$fell(busy) |-> st_r.span == SW'(CONV_CYC)) else $error("conversion time wrong");
	// tracking stays off for the whole busy span
	chk_hold_busy: assert property (@(posedge clk) disable iff (sys_rst)
		busy |-> !track) else $error("tracking during conversion");
	// busy only ever rises right after a launch
	chk_busy_rise: assert property (@(posedge clk) disable iff (sys_rst)
		$rose(busy) |-> $past(tmr_start)) else $error("busy raised without launch");
	// each start input launches exactly its own pair
	chk_pair_map: assert property (@(posedge clk) disable iff (sys_rst)
		tmr_start |=> st_r.pend == $past(rise)) else $error("wrong pairs launched");
	// results land for the launched pairs only
	chk_store_pairs: assert property (@(posedge clk) disable iff (sys_rst)
		tmr_done |=> st_r.valid == {{2{st_r.pend[2]}}, {2{st_r.pend[1]}},
		{2{st_r.pend[0]}}}) else $error("stored channels do not match pairs");
	// a start edge during a conversion leaves the pair selection alone
	chk_busy_drop: assert property (@(posedge clk) disable iff (sys_rst)
		(busy && (|rise)) |=> $stable(st_r.pend)) else $error("start taken while busy");

	// ------------------------------------------------------------
	// checks: readout lines
	// ------------------------------------------------------------
	// a released strobe releases the lines on the next cycle
	chk_rd_idle: assert property (@(posedge clk) disable iff (sys_rst)
		(rd_n_s || cs_n_s) |=> !(|data_oe)) else $error("lines driven after release");
	// word mode drives all sixteen lines during a read
	chk_word_lines: assert property (@(posedge clk) disable iff (sys_rst)
		(st_r.oe && wb_s == MODE_WORD) |-> data_oe == 16'hffff)
		else $error("word mode lines not all driven");
	// byte mode leaves the shared data7 pin and the lines below it alone
	chk_byte_low: assert property (@(posedge clk) disable iff (sys_rst)
		(st_r.oe && wb_s == MODE_BYTE && $stable(wb_s)) |-> data_oe == 16'hff00 &&
		data_out[7:0] == 8'h00) else $error("byte mode drives lower lines");
endmodule

// ### sxc_host.sv
// Purpose: host processor model on the parallel readout pins
// Assumes: pins change just after a falling clock edge
// Notes:   released data lines other than line 7 (byte order) flip every cycle, never keep a stale value
module sxc_host
	import sxc_pkg::*;
(
	input  wire logic              clk,
	input  wire logic              byte_order_select,
	input  wire logic [DATA_W-1:0] data_out,
	input  wire logic [DATA_W-1:0] data_oe,
	output logic                   start_pair_one_n,
	output logic                   start_pair_two_n,
	output logic                   start_pair_three_n,
	output logic                   chip_select_n,
	output logic                   read_n,
	output logic      [DATA_W-1:0] data_in
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [DATA_W-1:0] float_r;   // level seen on released lines
	logic [DATA_W-1:0] host_drv;  // what the host puts on the lines
	// --------------------------------------------------------------
	// idle pins: starts high, chip select low, returned low after each read
	// --------------------------------------------------------------
	initial begin
		float_r = 16'h5a5a;
		{start_pair_three_n, start_pair_two_n, start_pair_one_n} = 3'h7;
		chip_select_n = 1'b0;
		read_n = 1'b1;
	end
	// a released line must not look like the last driven value
	always @(negedge clk) float_r <= ~float_r;
	// bit 7 carries the byte order; lines 6..0 are left floating
	assign host_drv = {float_r[15:8], byte_order_select, float_r[6:0]};
	// device drive wins wherever its enable is high
	assign data_in = (data_oe & data_out) | (~data_oe & host_drv);
	// start pulse: falling edge, then rising edge on the chosen pairs
	task automatic pulse_start(input logic [2:0] mask);
		@(negedge clk);
		{start_pair_three_n, start_pair_two_n, start_pair_one_n} = ~mask;
		repeat (4) @(negedge clk);
		{start_pair_three_n, start_pair_two_n, start_pair_one_n} = 3'h7;
	endtask
	// one read strobe; len sets how slowly the host answers
	task automatic read_once(input logic cs_n, input int len);
		@(negedge clk);
		chip_select_n = cs_n;
		read_n = 1'b0;
		repeat (len) @(negedge clk);
		read_n = 1'b1;
		chip_select_n = 1'b0;
		repeat (len) @(negedge clk);
	endtask
endmodule

// ### testbench.sv
// Purpose: self-checking bench for the converter readout block
// Assumes: host model drives starts and reads; codes are random
// Notes:   12-bit and 14-bit copies share the pins to check their zero-filled tops
module testbench
	import sxc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int CONV_T = 20;  // short conversion keeps the run brief
	typedef struct packed {
		logic [15:0] d16;
		logic [15:0] d14;
		logic [15:0] d12;
		logic [15:0] oe;
	} sxc_note_type;
	logic         clk;
	logic         sys_rst;
	logic         word_byte_select;
	logic         order_sel;
	logic         s1_n, s2_n, s3_n, cs_n, rd_n;
	logic [15:0]  din, dout, doe, dout12, dout14;
	logic         busy, track;
	logic [15:0]  codes [6];       // per-channel codes, ch1 first
	logic [95:0]  sc16;
	logic [71:0]  sc12;
	logic [83:0]  sc14;
	logic         run_mon;         // watcher starts after reset
	int           n_fail, tests_run;
	sxc_note_type notes [$];       // expected results, oldest first
	always_comb for (int i = 0; i < 6; i++) begin
		sc16[i*16 +: 16] = codes[i];
		sc12[i*12 +: 12] = codes[i][11:0];
		sc14[i*14 +: 14] = codes[i][13:0];
	end
	sxc_host host (.clk(clk), .byte_order_select(order_sel), .data_out(dout), .data_oe(doe),
		.start_pair_one_n(s1_n), .start_pair_two_n(s2_n), .start_pair_three_n(s3_n),
		.chip_select_n(cs_n), .read_n(rd_n), .data_in(din));
	sxc_readout #(.RES_W(16), .CONV_CYC(CONV_T)) dut (.clk(clk), .sys_rst(sys_rst),
		.start_pair_one_n(s1_n), .start_pair_two_n(s2_n), .start_pair_three_n(s3_n),
		.serial_parallel_select(1'b0), .word_byte_select(word_byte_select),
		.chip_select_n(cs_n), .read_n(rd_n), .data_in(din), .data_out(dout),
		.data_oe(doe), .busy(busy), .track(track), .sample_code(sc16));
	sxc_readout #(.RES_W(12), .CONV_CYC(CONV_T)) dut12 (.clk(clk), .sys_rst(sys_rst),
		.start_pair_one_n(s1_n), .start_pair_two_n(s2_n), .start_pair_three_n(s3_n),
		.serial_parallel_select(1'b0), .word_byte_select(word_byte_select),
		.chip_select_n(cs_n), .read_n(rd_n), .data_in(din), .data_out(dout12),
		.data_oe(), .busy(), .track(), .sample_code(sc12));
	sxc_readout #(.RES_W(14), .CONV_CYC(CONV_T)) dut14 (.clk(clk), .sys_rst(sys_rst),
		.start_pair_one_n(s1_n), .start_pair_two_n(s2_n), .start_pair_three_n(s3_n),
		.serial_parallel_select(1'b0), .word_byte_select(word_byte_select),
		.chip_select_n(cs_n), .read_n(rd_n), .data_in(din), .data_out(dout14),
		.data_oe(), .busy(), .track(), .sample_code(sc14));
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	// --------------------------------------------------------------
	// reporting
	// --------------------------------------------------------------
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_fail++;
			$display("Error at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask
	task automatic final_report();
		$display("comparisons %0d, mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	task automatic give_up();
		n_fail++;
		$display("Error at %0t: wait limit ran out", $time);
		final_report();
	endtask
	// watcher: each time the device drives, compare with the oldest note
	initial begin
		sxc_note_type nt;
		wait (run_mon === 1'b1);
		forever begin
			@(posedge (|doe));
			repeat (2) @(negedge clk);
			if (notes.size() == 0) check(doe, 16'h0);
			else begin
				nt = notes.pop_front();
				check(dout & nt.oe, nt.d16);
				check(doe, nt.oe);
				check(dout12 & nt.oe, nt.d12);
				check(dout14 & nt.oe, nt.d14);
			end
		end
	end
	// --------------------------------------------------------------
	// stimulus
	// --------------------------------------------------------------
	// conversion; extra pairs are pulsed mid-busy and must be dropped
	task automatic convert(input logic [2:0] mask, input logic [2:0] extra);
		int n;
		int pre;
		for (int i = 0; i < 6; i++) codes[i] = 16'($urandom);
		host.pulse_start(mask);
		n = 0;
		while (busy !== 1'b1 && n < 20) begin
			@(negedge clk);
			n++;
		end
		if (n == 20) give_up();
		check(16'(track), 16'h0);
		pre = 0;
		if (extra != 3'h0) begin
			host.pulse_start(extra);
			pre = 5;
		end
		n = 0;
		while (busy === 1'b1 && n < 200) begin
			@(negedge clk);
			n++;
		end
		check(16'(n + pre), 16'(CONV_T));
		repeat (2) @(negedge clk);
		check(16'(track), 16'h1);
	endtask
	// reads after busy low; notes each expected word or byte first
	task automatic read_all(input logic [2:0] mask, input logic bm, input logic hf,
		input int lim);
		logic [15:0] w16;
		logic [15:0] w14;
		logic [15:0] w12;
		logic        hb;
		int          k;
		k = 0;
		for (int c = 0; c < 6; c++) begin
			for (int b = 0; b < 2; b++) begin
				if (mask[c/2] && (bm || b == 0) && k < lim) begin
					w16 = codes[c];
					w12 = {4'h0, codes[c][11:0]};
					w14 = {2'h0, codes[c][13:0]};
					hb = (b == 1) ^ hf;
					if (bm) begin
						w16 = hb ? {w16[15:8], 8'h00} : {w16[7:0], 8'h00};
						w12 = hb ? {w12[15:8], 8'h00} : {w12[7:0], 8'h00};
						w14 = hb ? {w14[15:8], 8'h00} : {w14[7:0], 8'h00};
					end
					notes.push_back({w16, w14, w12, bm ? 16'hff00 : 16'hffff});
					host.read_once(1'b0, 6 + $urandom_range(6));
					k++;
				end
			end
		end
		check(doe, 16'h0);
	endtask
	initial begin
		repeat (50000) @(negedge clk);
		give_up();
	end
	initial begin
		sys_rst = 1'b1;
		word_byte_select = MODE_WORD;
		order_sel = ORDER_LOW_FIRST;
		run_mon = 1'b0;
		n_fail = 0;
		tests_run = 0;
		for (int i = 0; i < 6; i++) codes[i] = 16'h0;
		void'($urandom(24112));
		repeat (10) @(negedge clk);
		sys_rst = 1'b0;
		check(16'({busy, track}), 16'h1);
		check(doe, 16'h0);
		repeat (6) @(negedge clk);
		run_mon = 1'b1;
		// every pair combination, word mode
		for (int m = 1; m < 8; m++) begin
			convert(3'(m), 3'h0);
			read_all(3'(m), 1'b0, 1'b0, 12);
		end
		convert(3'h1, 3'h6);
		read_all(3'h1, 1'b0, 1'b0, 12);
		host.read_once(1'b1, 8);
		convert(3'h7, 3'h0);
		read_all(3'h7, 1'b0, 1'b0, 2);
		convert(3'h2, 3'h0);
		read_all(3'h2, 1'b0, 1'b0, 12);
		// byte mode, both byte orders
		word_byte_select = MODE_BYTE;
		repeat (8) @(negedge clk);
		for (int o = 0; o < 2; o++) begin
			order_sel = o[0];
			convert(3'h7, 3'h0);
			read_all(3'h7, 1'b1, o[0], 12);
		end
		final_report();
	end
endmodule
